// *** common/adc_regs_pkg.sv ***
// constants, selector codes and link states for the converter register front end
package adc_regs_pkg;
    // selector codes of the eight data registers
    localparam logic [2:0] SEL_RESULT   = 3'h0;
    localparam logic [2:0] SEL_ALARM    = 3'h1;
    localparam logic [2:0] SEL_CONFIG   = 3'h2;
    localparam logic [2:0] SEL_LOWER    = 3'h3;
    localparam logic [2:0] SEL_UPPER    = 3'h4;
    localparam logic [2:0] SEL_DEADBAND = 3'h5;
    localparam logic [2:0] SEL_LOWEST   = 3'h6;
    localparam logic [2:0] SEL_HIGHEST  = 3'h7;

    // widths
    localparam int SEL_W        = 3;
    localparam int BYTE_W       = 8;
    localparam int WORD_W       = 16;
    localparam int FLAG_W       = 2;
    localparam int SAMPLE_W_DOC = 12;
    localparam int ADDR_W       = 7;

    // reset values
    localparam logic [15:0] RESULT_RST   = 16'h0000;
    localparam logic [7:0]  ALARM_RST    = 8'h00;
    localparam logic [7:0]  SELECTOR_RST = 8'h00;

    // field positions
    localparam int OVER_BIT    = 1;
    localparam int UNDER_BIT   = 0;
    localparam int SUMMARY_BIT = 15;

    // last bit index within a byte
    localparam logic [2:0] BIT_LAST = 3'h7;

    // bus address of the device; value is arbitrary
    localparam logic [6:0] DEV_ADDR_DFLT = 7'h2a;

    // two-wire slave states, gray coded along the usual path
    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_ADDR      = 3'b001,
        ST_ADDR_ACK  = 3'b011,
        ST_WRITE     = 3'b010,
        ST_WRITE_ACK = 3'b110,
        ST_READ      = 3'b111,
        ST_HOST_ACK  = 3'b101
    } link_state_t;
endpackage

// *** verilog/two_wire_byte_slave.sv ***
// two-wire serial slave turning bits into bytes and back
`timescale 1ns/1ns
module two_wire_byte_slave #(
    parameter logic [6:0] DEV_ADDR = adc_regs_pkg::DEV_ADDR_DFLT
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             frame_start,
    output logic             addr_hit,
    output logic             addr_read,
    output logic             rx_valid,
    output logic [7:0]       rx_data,
    output logic             tx_taken,
    input  wire logic [7:0]  tx_data
);
    import adc_regs_pkg::*;

    logic        scl_ff;
    logic        sda_ff;
    link_state_t state_ff;
    logic [2:0]  bit_cnt_ff;
    logic [7:0]  shift_ff;
    logic        full_ff;
    logic        read_ff;
    logic        sda_oe_ff;
    logic        start_cond;
    logic        stop_cond;
    logic        scl_rise;
    logic        scl_fall;
    logic        addr_match;

    // -----------------------------------------------------------------
    // line events
    // -----------------------------------------------------------------
    // previous line levels for edge and condition detection
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
        end else begin
            scl_ff <= scl_in;
            sda_ff <= sda_in;
        end
    end

    // start and stop are data changes while the clock line is high
    assign start_cond = scl_in & scl_ff & sda_ff & ~sda_in;
    assign stop_cond  = scl_in & scl_ff & ~sda_ff & sda_in;
    assign scl_rise   = scl_in & ~scl_ff;
    assign scl_fall   = ~scl_in & scl_ff;
    assign addr_match = (shift_ff[7:1] == DEV_ADDR);

    // -----------------------------------------------------------------
    // byte state machine
    // -----------------------------------------------------------------
    // bits are taken on rising clock, the data line changes on falling
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_ff   <= ST_IDLE;
            bit_cnt_ff <= 3'h0;
            shift_ff   <= 8'h00;
            full_ff    <= 1'b0;
            read_ff    <= 1'b0;
            sda_oe_ff  <= 1'b0;
        end else if (start_cond) begin
            state_ff   <= ST_ADDR;
            bit_cnt_ff <= 3'h0;
            full_ff    <= 1'b0;
            sda_oe_ff  <= 1'b0;
        end else if (stop_cond) begin
            state_ff  <= ST_IDLE;
            sda_oe_ff <= 1'b0;
        end else if (scl_rise) begin
            unique case (state_ff)
                ST_ADDR, ST_WRITE: begin
                    shift_ff   <= {shift_ff[6:0], sda_in};
                    bit_cnt_ff <= 3'(bit_cnt_ff + 3'h1);
                    full_ff    <= (bit_cnt_ff == BIT_LAST);
                end
                ST_HOST_ACK: begin
                    if (sda_in) begin
                        state_ff <= ST_IDLE; // host ends the read
                    end
                end
                default: ;
            endcase
        end else if (scl_fall) begin
            unique case (state_ff)
                ST_ADDR: begin
                    if (full_ff) begin
                        full_ff <= 1'b0;
                        if (addr_match) begin
                            state_ff  <= ST_ADDR_ACK;
                            sda_oe_ff <= 1'b1;
                            read_ff   <= shift_ff[0];
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                ST_WRITE: begin
                    if (full_ff) begin
                        full_ff   <= 1'b0;
                        state_ff  <= ST_WRITE_ACK;
                        sda_oe_ff <= 1'b1;
                    end
                end
                ST_WRITE_ACK: begin
                    state_ff  <= ST_WRITE;
                    sda_oe_ff <= 1'b0;
                end
                ST_ADDR_ACK, ST_HOST_ACK: begin
                    if (state_ff == ST_ADDR_ACK && !read_ff) begin
                        state_ff  <= ST_WRITE;
                        sda_oe_ff <= 1'b0;
                    end else begin
                        state_ff   <= ST_READ;
                        shift_ff   <= tx_data;
                        bit_cnt_ff <= 3'h0;
                        sda_oe_ff  <= ~tx_data[7];
                    end
                end
                ST_READ: begin
                    if (bit_cnt_ff == BIT_LAST) begin
                        state_ff   <= ST_HOST_ACK;
                        bit_cnt_ff <= 3'h0;
                        sda_oe_ff  <= 1'b0;
                    end else begin
                        shift_ff   <= {shift_ff[6:0], 1'b0};
                        bit_cnt_ff <= 3'(bit_cnt_ff + 3'h1);
                        sda_oe_ff  <= ~shift_ff[6];
                    end
                end
                default: ;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // pulses toward the register bank
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            frame_start <= 1'b0;
            addr_hit    <= 1'b0;
            rx_valid    <= 1'b0;
            rx_data     <= 8'h00;
            tx_taken    <= 1'b0;
        end else begin
            frame_start <= start_cond;
            addr_hit    <= scl_fall & (state_ff == ST_ADDR) & full_ff & addr_match;
            rx_valid    <= scl_fall & (state_ff == ST_WRITE) & full_ff;
            rx_data     <= shift_ff;
            tx_taken    <= scl_fall & (((state_ff == ST_ADDR_ACK) & read_ff) | (state_ff == ST_HOST_ACK));
        end
    end

    // open drain: the line is only ever pulled low
    assign sda_out   = 1'b0;
    assign sda_oe    = sda_oe_ff;
    assign addr_read = read_ff;
endmodule

// *** verilog/adc_pointer_result_alert_regs.sv ***
// selector, result word and alarm flags of the converter behind a two-wire slave
`timescale 1ns/1ns
module adc_pointer_result_alert_regs #(
    parameter int         SAMPLE_W = adc_regs_pkg::SAMPLE_W_DOC,
    parameter logic [6:0] DEV_ADDR = adc_regs_pkg::DEV_ADDR_DFLT
) (
    input  wire logic                             clock,
    input  wire logic                             resetn,
    input  wire logic                             scl_in,
    input  wire logic                             sda_in,
    output logic                                  sda_out,
    output logic                                  sda_oe,
    input  wire logic                             sample_valid,
    input  wire logic [SAMPLE_W-1:0]              sample_data,
    input  wire logic [SAMPLE_W-1:0]              upper_threshold,
    input  wire logic [SAMPLE_W-1:0]              lower_threshold,
    input  wire logic [SAMPLE_W-1:0]              threshold_deadband,
    input  wire logic                             alert_hold,
    input  wire logic                             summary_enable,
    output logic                                  convert_start,
    output logic [adc_regs_pkg::SEL_W-1:0]        ext_sel,
    output logic                                  ext_wr,
    output logic [adc_regs_pkg::WORD_W-1:0]       ext_wdata,
    input  wire logic [adc_regs_pkg::WORD_W-1:0]  ext_rdata,
    output logic [adc_regs_pkg::FLAG_W-1:0]       alarm_flags
);
    import adc_regs_pkg::*;

    // -----------------------------------------------------------------
    // parameter check
    // -----------------------------------------------------------------
    // the sample must leave the summary bit free
    if (SAMPLE_W < 1 || SAMPLE_W > SUMMARY_BIT) begin : g_bad_width
        $error("SAMPLE_W must lie between 1 and 15");
    end

    // -----------------------------------------------------------------
    // functions
    // -----------------------------------------------------------------
    // alarm and configuration are one byte, all others two
    function automatic logic is_wide(input logic [SEL_W-1:0] sel);
        is_wide = (sel != SEL_ALARM) && (sel != SEL_CONFIG);
    endfunction

    // sample below upper minus deadband, without underflow
    function automatic logic below_band(input logic [SAMPLE_W-1:0] s,
                                        input logic [SAMPLE_W-1:0] u,
                                        input logic [SAMPLE_W-1:0] d);
        below_band = ({1'b0, s} + {1'b0, d}) < {1'b0, u};
    endfunction

    // sample above lower plus deadband, without overflow
    function automatic logic above_band(input logic [SAMPLE_W-1:0] s,
                                        input logic [SAMPLE_W-1:0] l,
                                        input logic [SAMPLE_W-1:0] d);
        above_band = {1'b0, s} > ({1'b0, l} + {1'b0, d});
    endfunction

    // -----------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------
    logic                frame_start;
    logic                addr_hit;
    logic                addr_read;
    logic                rx_valid;
    logic [BYTE_W-1:0]   rx_data;
    logic                tx_taken;
    logic [BYTE_W-1:0]   tx_byte_ff;
    logic [BYTE_W-1:0]   lo_byte_ff;
    logic                lo_pending_ff;
    logic [BYTE_W-1:0]   selector_ff;
    logic                expect_sel_ff;
    logic                hi_pending_ff;
    logic [BYTE_W-1:0]   hi_byte_ff;
    logic [SAMPLE_W-1:0] result_ff;
    logic [FLAG_W-1:0]   alarm_ff;
    logic [FLAG_W-1:0]   nxt_alarm;
    logic                convert_start_ff;
    logic                ext_wr_ff;
    logic [WORD_W-1:0]   ext_wdata_ff;
    logic [SEL_W-1:0]    sel;
    logic                wide;
    logic                commit;
    logic [WORD_W-1:0]   wr_word;
    logic [WORD_W-1:0]   rd_word;
    logic                summary;
    logic                read_begin;

    // -----------------------------------------------------------------
    // serial link
    // -----------------------------------------------------------------
    two_wire_byte_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) two_wire_byte_slave_inst (
        .clock       (clock),
        .resetn      (resetn),
        .scl_in      (scl_in),
        .sda_in      (sda_in),
        .sda_out     (sda_out),
        .sda_oe      (sda_oe),
        .frame_start (frame_start),
        .addr_hit    (addr_hit),
        .addr_read   (addr_read),
        .rx_valid    (rx_valid),
        .rx_data     (rx_data),
        .tx_taken    (tx_taken),
        .tx_data     (tx_byte_ff)
    );

    // -----------------------------------------------------------------
    // selector and write assembly
    // -----------------------------------------------------------------
    // only the low selector bits decode a register
    assign sel  = selector_ff[SEL_W-1:0];
    assign wide = is_wide(sel);

    // a data byte completes a write when the register is full
    assign commit  = rx_valid & ~expect_sel_ff & (~wide | hi_pending_ff);
    assign wr_word = wide ? {hi_byte_ff, rx_data} : {{(WORD_W-BYTE_W){1'b0}}, rx_data};

    // first data byte of every write frame is the selector
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            selector_ff   <= SELECTOR_RST;
            expect_sel_ff <= 1'b0;
            hi_pending_ff <= 1'b0;
            hi_byte_ff    <= 8'h00;
        end else if (frame_start) begin
            expect_sel_ff <= 1'b0;
            hi_pending_ff <= 1'b0;
        end else if (addr_hit && !addr_read) begin
            expect_sel_ff <= 1'b1;
            hi_pending_ff <= 1'b0;
        end else if (rx_valid) begin
            if (expect_sel_ff) begin
                selector_ff   <= rx_data;
                expect_sel_ff <= 1'b0;
            end else if (wide && !hi_pending_ff) begin
                hi_byte_ff    <= rx_data;
                hi_pending_ff <= 1'b1;
            end else begin
                hi_pending_ff <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // outside registers
    // -----------------------------------------------------------------
    // configuration, limits and extremes live beyond this block
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ext_wr_ff    <= 1'b0;
            ext_wdata_ff <= 16'h0000;
        end else begin
            ext_wr_ff <= commit & (sel != SEL_RESULT) & (sel != SEL_ALARM);
            if (commit) begin
                ext_wdata_ff <= wr_word;
            end
        end
    end

    assign ext_sel   = sel;
    assign ext_wr    = ext_wr_ff;
    assign ext_wdata = ext_wdata_ff;

    // -----------------------------------------------------------------
    // conversion result
    // -----------------------------------------------------------------
    // only a finished conversion updates the word, never the bus
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            result_ff <= RESULT_RST[SAMPLE_W-1:0];
        end else if (sample_valid) begin
            result_ff <= sample_data;
        end
    end

    // -----------------------------------------------------------------
    // alarm flags
    // -----------------------------------------------------------------
    // a set in the same cycle as a clear wins
    always_comb begin
        nxt_alarm = alarm_ff;
        if (commit && sel == SEL_ALARM && wr_word[OVER_BIT]) begin
            nxt_alarm[OVER_BIT] = 1'b0;
        end
        if (commit && sel == SEL_ALARM && wr_word[UNDER_BIT]) begin
            nxt_alarm[UNDER_BIT] = 1'b0;
        end
        if (sample_valid) begin
            if (!alert_hold && below_band(sample_data, upper_threshold, threshold_deadband)) begin
                nxt_alarm[OVER_BIT] = 1'b0;
            end
            if (!alert_hold && above_band(sample_data, lower_threshold, threshold_deadband)) begin
                nxt_alarm[UNDER_BIT] = 1'b0;
            end
            if (sample_data > upper_threshold) begin
                nxt_alarm[OVER_BIT] = 1'b1;
            end
            if (sample_data < lower_threshold) begin
                nxt_alarm[UNDER_BIT] = 1'b1;
            end
        end
    end

    // flag storage
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            alarm_ff <= ALARM_RST[FLAG_W-1:0];
        end else begin
            alarm_ff <= nxt_alarm;
        end
    end

    assign alarm_flags = alarm_ff;

    // -----------------------------------------------------------------
    // read path
    // -----------------------------------------------------------------
    // summary bit shows either flag while enabled
    assign summary = summary_enable & (|alarm_ff);

    // word behind the current selector
    always_comb begin
        rd_word = '0;
        unique case (sel)
            SEL_RESULT: begin
                rd_word[SAMPLE_W-1:0]  = result_ff;
                rd_word[SUMMARY_BIT]   = summary;
            end
            SEL_ALARM: begin
                rd_word[FLAG_W-1:0] = alarm_ff;
            end
            default: begin
                rd_word = ext_rdata;
            end
        endcase
    end

    assign read_begin = addr_hit & addr_read;

    // next byte to shift out, high byte of a wide register first
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tx_byte_ff    <= 8'h00;
            lo_byte_ff    <= 8'h00;
            lo_pending_ff <= 1'b0;
        end else if (read_begin || (tx_taken && !lo_pending_ff)) begin
            tx_byte_ff    <= wide ? rd_word[WORD_W-1:BYTE_W] : rd_word[BYTE_W-1:0];
            lo_byte_ff    <= rd_word[BYTE_W-1:0];
            lo_pending_ff <= wide;
        end else if (tx_taken) begin
            tx_byte_ff    <= lo_byte_ff;
            lo_pending_ff <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // conversion request
    // -----------------------------------------------------------------
    // a read of the result word asks the converter for a new sample
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            convert_start_ff <= 1'b0;
        end else begin
            convert_start_ff <= read_begin & (sel == SEL_RESULT);
        end
    end

    assign convert_start = convert_start_ff;
endmodule

// *** test/adc_regs_props.sv ***
// assertion checker for the register front end
`timescale 1ns/1ns
module adc_regs_props
    import adc_regs_pkg::*;
#(
    parameter int SAMPLE_W = 12
) (
    input wire logic                              clock,
    input wire logic                              resetn,
    input wire logic                              sda_oe,
    input wire logic                              sample_valid,
    input wire logic [SAMPLE_W-1:0]               sample_data,
    input wire logic [SAMPLE_W-1:0]               upper_threshold,
    input wire logic [SAMPLE_W-1:0]               lower_threshold,
    input wire logic [SAMPLE_W-1:0]               threshold_deadband,
    input wire logic                              alert_hold,
    input wire logic                              convert_start,
    input wire logic [adc_regs_pkg::SEL_W-1:0]    ext_sel,
    input wire logic                              ext_wr,
    input wire logic [adc_regs_pkg::FLAG_W-1:0]   alarm_flags
);
    // ----
    // flag and bus relations
    // ----
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // sample events
    sequence s_hi;
        sample_valid && sample_data > upper_threshold;
    endsequence
    sequence s_lo;
        sample_valid && sample_data < lower_threshold;
    endsequence
    sequence s_hi_band;
        sample_valid && !alert_hold && int'(sample_data) + int'(threshold_deadband) < int'(upper_threshold);
    endsequence
    sequence s_lo_band;
        sample_valid && !alert_hold && int'(sample_data) > int'(lower_threshold) + int'(threshold_deadband);
    endsequence
    property p_over_set;
        s_hi |=> alarm_flags[OVER_BIT];
    endproperty
    a_over_set: assert property (p_over_set) else $error("over flag not set");
    property p_under_set;
        s_lo |=> alarm_flags[UNDER_BIT];
    endproperty
    a_under_set: assert property (p_under_set) else $error("under flag not set");
    property p_over_band;
        s_hi_band ##0 alarm_flags[OVER_BIT] |=> !alarm_flags[OVER_BIT];
    endproperty
    a_over_band: assert property (p_over_band) else $error("over flag kept");
    property p_under_band;
        s_lo_band ##0 alarm_flags[UNDER_BIT] |=> !alarm_flags[UNDER_BIT];
    endproperty
    a_under_band: assert property (p_under_band) else $error("under flag kept");
    property p_hold;
        alert_hold && sample_valid && alarm_flags[UNDER_BIT] |=> alarm_flags[UNDER_BIT];
    endproperty
    a_hold: assert property (p_hold) else $error("held flag lost");
    property p_over_cause;
        $rose(alarm_flags[OVER_BIT]) |-> $past(sample_valid);
    endproperty
    a_over_cause: assert property (p_over_cause) else $error("over flag without sample");
    property p_wr_code;
        ext_wr |-> ext_sel >= SEL_CONFIG;
    endproperty
    a_wr_code: assert property (p_wr_code) else $error("write to internal code");
    property p_conv_ack;
        convert_start |-> sda_oe;
    endproperty
    a_conv_ack: assert property (p_conv_ack) else $error("start outside ack");
endmodule
bind adc_pointer_result_alert_regs adc_regs_props #(.SAMPLE_W(SAMPLE_W)) adc_regs_props_inst (
    .clock(clock), .resetn(resetn), .sda_oe(sda_oe), .sample_valid(sample_valid), .sample_data(sample_data),
    .upper_threshold(upper_threshold), .lower_threshold(lower_threshold),
    .threshold_deadband(threshold_deadband), .alert_hold(alert_hold), .convert_start(convert_start),
    .ext_sel(ext_sel), .ext_wr(ext_wr), .alarm_flags(alarm_flags));

// *** test/i2c_host_model.sv ***
// two-wire bus controller model
`timescale 1ns/1ns
module i2c_host_model (
    input wire logic clock,
    input wire logic sda_line,
    output logic     scl,
    output logic     sda_drv
);
    // ----
    // bus phases, lines move at falling edge
    // ----
    // idle lines released high
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic half();
        repeat (6) @(negedge clock);
    endtask
    task automatic start();
        sda_drv = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_drv = 1'b0;
        half();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_drv = 1'b1;
        half();
    endtask
    // msb first, ack sampled at end of high phase
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_drv = b[i];
            half();
            scl = 1'b1;
            half();
            scl = 1'b0;
        end
        sda_drv = 1'b1;
        half();
        scl = 1'b1;
        half();
        ack = !sda_line;
        scl = 1'b0;
    endtask
    task automatic get_byte(input logic last, output logic [7:0] b);
        sda_drv = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            half();
            scl = 1'b1;
            half();
            b[i] = sda_line;
            scl = 1'b0;
        end
        sda_drv = last;
        half();
        scl = 1'b1;
        half();
        scl = 1'b0;
        sda_drv = 1'b1;
    endtask
endmodule

// *** test/tb_top.sv ***
// self-checking bench for the register front end
`timescale 1ns/1ns
module tb_top;
    import adc_regs_pkg::*;
    // ----
    // signals and instances
    // ----
    logic        clock, resetn, scl, sda_drv, sda_oe, sda_out, sv, al_hold, sum_en, conv, ext_wr, ack;
    logic [11:0] sdata, upper, lower, band;
    logic [15:0] rdata, wdata, got, wword;
    logic [2:0]  esel, wsel;
    logic [1:0]  flags;
    int          n_fail = 0, total_checks = 0, n_conv = 0;
    wire         sda_in = sda_drv & (~sda_oe | sda_out);
    i2c_host_model i2c_host_model_inst (.clock(clock), .sda_line(sda_in), .scl(scl), .sda_drv(sda_drv));
    adc_pointer_result_alert_regs adc_pointer_result_alert_regs_inst (
        .clock(clock), .resetn(resetn), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .sample_valid(sv), .sample_data(sdata), .upper_threshold(upper), .lower_threshold(lower),
        .threshold_deadband(band), .alert_hold(al_hold), .summary_enable(sum_en), .convert_start(conv),
        .ext_sel(esel), .ext_wr(ext_wr), .ext_wdata(wdata), .ext_rdata(rdata), .alarm_flags(flags));
    // clock and outside-write monitor
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (conv === 1'b1) n_conv <= n_conv + 1;
        if (ext_wr === 1'b1) begin
            wsel <= esel;
            wword <= wdata;
        end
    end
    // ----
    // tasks
    // ----
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] sel, input int n, input logic [15:0] d);
        i2c_host_model_inst.start();
        i2c_host_model_inst.put_byte({DEV_ADDR_DFLT, 1'b0}, ack);
        chk({15'h0, ack}, 16'h1);
        i2c_host_model_inst.put_byte(sel, ack);
        if (n == 2) i2c_host_model_inst.put_byte(d[15:8], ack);
        if (n > 0) i2c_host_model_inst.put_byte(d[7:0], ack);
        i2c_host_model_inst.stop();
    endtask
    task automatic rd(input int n, output logic [15:0] g);
        g = 16'h0;
        i2c_host_model_inst.start();
        i2c_host_model_inst.put_byte({DEV_ADDR_DFLT, 1'b1}, ack);
        if (n == 2) i2c_host_model_inst.get_byte(1'b0, g[15:8]);
        i2c_host_model_inst.get_byte(1'b1, g[7:0]);
        i2c_host_model_inst.stop();
    endtask
    task automatic smp(input logic [11:0] v);
        @(negedge clock);
        sdata = v;
        sv = 1'b1;
        @(negedge clock);
        sv = 1'b0;
        @(negedge clock);
    endtask
    task automatic t_reset();
        rd(2, got);
        chk(got, RESULT_RST);
        chk(16'(n_conv), 16'h1);
        chk({14'h0, flags}, 16'h0);
    endtask
    task automatic t_alarm();
        smp(12'h8ff);
        chk({14'h0, flags}, 16'h2);
        sum_en = 1'b1;
        rd(2, got);
        chk(got, 16'h88ff);
        sum_en = 1'b0;
        rd(2, got);
        chk(got, 16'h08ff);
        wr(8'h01, 0, 16'h0);
        rd(1, got);
        chk(got, 16'h0002);
        wr(8'h01, 1, 16'h0000);
        chk({14'h0, flags}, 16'h2);
        wr(8'h01, 1, 16'h0002);
        chk({14'h0, flags}, 16'h0);
    endtask
    task automatic t_band();
        smp(12'h050);
        chk({14'h0, flags}, 16'h1);
        al_hold = 1'b1;
        smp(12'h400);
        chk({14'h0, flags}, 16'h1);
        wr(8'h01, 1, 16'h0001);
        chk({14'h0, flags}, 16'h0);
        smp(12'h900);
        al_hold = 1'b0;
        smp(12'h7f8);
        chk({14'h0, flags}, 16'h2);
        smp(12'h7ef);
        chk({14'h0, flags}, 16'h0);
        smp(12'h050);
        smp(12'h110);
        chk({14'h0, flags}, 16'h1);
        smp(12'h111);
        chk({14'h0, flags}, 16'h0);
    endtask
    task automatic t_route();
        wr(8'h04, 2, 16'h0123);
        chk({13'h0, wsel}, 16'h4);
        chk(wword, 16'h0123);
        wr(8'h00, 2, 16'hffff);
        rd(2, got);
        chk(got, 16'h0111);
        chk(wword, 16'h0123);
        wr(8'h02, 1, 16'h00a5);
        chk(wword, 16'h00a5);
        wr(8'h0b, 0, 16'h0);
        chk({13'h0, esel}, 16'h3);
        rd(2, got);
        chk(got, 16'h0abc);
    endtask
    // ----
    // main sequence and watchdog
    // ----
    initial begin
        resetn = 1'b0;
        sv = 1'b0;
        sdata = 12'h0;
        upper = 12'h800;
        lower = 12'h100;
        band = 12'h010;
        al_hold = 1'b0;
        sum_en = 1'b0;
        rdata = 16'h0abc;
        repeat (20) @(posedge clock);
        @(negedge clock);
        resetn = 1'b1;
        t_reset();
        t_alarm();
        t_band();
        t_route();
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge clock);
        n_fail++;
        end_of_test();
    end
endmodule
